// File: rtl/sgp_pkg.sv
//------------------------------------------------------------
// Functional notes
// RULE1: pin usable only in single-wire mode
// RULE2: pin is input until initialisation done
// RULE3: first wake loads mode, sets pin
// RULE4: pin state holds through sleep, idle
// RULE5: disabled mode: input, requests return error
// RULE6: two-wire mode: requests return error
// RULE7: authorised low: output, low at wake
// RULE8: non-default level needs prior key authorization
// RULE9: return to default needs no authorization
// RULE10: authorised high: like low, default high
// RULE11: intrusion: input, latch cleared at power-up
// RULE12: latch set by auth, falling edge clears
// RULE13: intrusion read returns latch value
// RULE14: input mode: read returns live pin
// RULE15: free low: low at wake, free drive
// RULE16: free modes may switch pin to input
// RULE17: free high: like free low, starts high
// RULE18: output drives both levels actively
// RULE19: system floats pin to dim LED
// RULE20: request op plus auth flag, result/error
package sgp_pkg;
    localparam int MODE_W = 4;
    localparam int BIT_INTR = 3;
    localparam int BIT_DEF = 2;

    typedef enum logic [1:0] {
        SGP_OP_READ = 2'b00,
        SGP_OP_HIGH = 2'b01,
        SGP_OP_LOW = 2'b10,
        SGP_OP_INPUT = 2'b11
    } sgp_op_t;

    typedef enum logic [2:0] {
        SGP_DISABLED = 3'b000,
        SGP_AUTH_OUT_LOW = 3'b001,
        SGP_AUTH_OUT_HIGH = 3'b010,
        SGP_INTRUSION = 3'b011,
        SGP_INPUT = 3'b100,
        SGP_FREE_OUT_LOW = 3'b101,
        SGP_FREE_OUT_HIGH = 3'b110
    } sgp_mode_t;

    typedef struct packed {
        sgp_op_t op;
        logic authOk;
    } sgp_req_t;

    typedef struct packed {
        logic error;
        logic level;
    } sgp_rsp_t;
endpackage

// File: rtl/sgp_pin_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module sgp_pin_ctrl (
    input wire logic ref_clk,                   // 20 MHz clock
    input wire logic rst_b,                     // sync reset, power-up
    input wire logic singleWireEn,              // single-wire selected
    input wire logic firstWake,                 // init pulse, 1st wake
    input wire logic [3:0] modeCfg,             // mode field of cfg byte
    input wire logic authSet,                   // key auth success pulse
    input wire logic reqValid,                  // info request strobe
    input wire sgp_pkg::sgp_req_t req,          // op and auth flag
    output logic rspValid,                      // answer strobe
    output var sgp_pkg::sgp_rsp_t rsp,          // result or error
    output var sgp_pkg::sgp_mode_t modeOut,     // decoded mode
    input wire logic pinIn,                     // pad input
    output logic pinOut,                        // pad output level
    output logic pinOe_b                        // low while driving
);
    import sgp_pkg::*;

    //------------------------------------------------------------
    // mode decode
    //------------------------------------------------------------
    sgp_mode_t mode_r;
    logic initDone_r;
    logic drive_r;
    logic level_r;
    logic latch_r;
    logic pinPrev_r;
    logic rspValid_r;
    sgp_rsp_t rsp_r;
    sgp_mode_t decMode;
    logic isAuth;
    logic isFree;
    logic defLevel;
    logic fallEdge;

    always_comb begin
        decMode = SGP_DISABLED;
        if (modeCfg[1:0] == 2'b00) begin
            decMode = SGP_DISABLED;
        end else if (modeCfg[1:0] == 2'b10) begin
            decMode = SGP_INPUT;                    // RULE14
        end else if (modeCfg[1:0] == 2'b11) begin
            decMode = modeCfg[BIT_DEF] ? SGP_FREE_OUT_HIGH
                                       : SGP_FREE_OUT_LOW;
        end else if (modeCfg[BIT_INTR]) begin
            decMode = SGP_INTRUSION;                // RULE11
        end else begin
            decMode = modeCfg[BIT_DEF] ? SGP_AUTH_OUT_HIGH
                                       : SGP_AUTH_OUT_LOW;
        end
    end

    assign isAuth = (mode_r == SGP_AUTH_OUT_LOW) ||
                    (mode_r == SGP_AUTH_OUT_HIGH);
    assign isFree = (mode_r == SGP_FREE_OUT_LOW) ||
                    (mode_r == SGP_FREE_OUT_HIGH);
    assign defLevel = (mode_r == SGP_AUTH_OUT_HIGH) ||
                      (mode_r == SGP_FREE_OUT_HIGH);  // RULE10 RULE17
    assign fallEdge = pinPrev_r & ~pinIn;

    //------------------------------------------------------------
    // init and mode capture
    //------------------------------------------------------------
    // mode is captured once; later config edits wait for power-up
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            initDone_r <= 1'b0;
            mode_r <= SGP_DISABLED;
        end else if (firstWake && !initDone_r) begin
            initDone_r <= 1'b1;                     // RULE3
            mode_r <= singleWireEn ? decMode : SGP_DISABLED;  // RULE1
        end
    end

    //------------------------------------------------------------
    // pin direction and level
    //------------------------------------------------------------
    // nothing here depends on sleep or idle, so state simply holds
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            drive_r <= 1'b0;                        // RULE2
            level_r <= 1'b0;
        end else if (firstWake && !initDone_r) begin
            drive_r <= singleWireEn && ((decMode == SGP_AUTH_OUT_LOW) ||
                       (decMode == SGP_AUTH_OUT_HIGH) ||
                       (decMode == SGP_FREE_OUT_LOW) ||
                       (decMode == SGP_FREE_OUT_HIGH));  // RULE7 RULE15
            level_r <= modeCfg[BIT_DEF];            // RULE10 RULE17
        end else if (reqValid && initDone_r && singleWireEn) begin
            if (isAuth) begin
                if (req.op == SGP_OP_HIGH || req.op == SGP_OP_LOW) begin
                    if ((req.op == SGP_OP_HIGH) == defLevel) begin
                        level_r <= defLevel;        // RULE9
                    end else if (req.authOk) begin
                        level_r <= ~defLevel;       // RULE8
                    end
                end
            end else if (isFree) begin
                if (req.op == SGP_OP_HIGH) begin
                    drive_r <= 1'b1;
                    level_r <= 1'b1;
                end else if (req.op == SGP_OP_LOW) begin
                    drive_r <= 1'b1;
                    level_r <= 1'b0;
                end else if (req.op == SGP_OP_INPUT) begin
                    drive_r <= 1'b0;                // RULE16
                end
            end
        end
    end

    //------------------------------------------------------------
    // intrusion latch
    //------------------------------------------------------------
    // clear wins over set: a tamper edge must never be masked
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            latch_r <= 1'b0;                        // RULE11
            pinPrev_r <= 1'b0;
        end else begin
            pinPrev_r <= pinIn;
            if (mode_r == SGP_INTRUSION && fallEdge) begin
                latch_r <= 1'b0;                    // RULE12
            end else if (mode_r == SGP_INTRUSION && authSet) begin
                latch_r <= 1'b1;                    // RULE12
            end
        end
    end

    //------------------------------------------------------------
    // request answer
    //------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rspValid_r <= 1'b0;
            rsp_r <= '0;
        end else begin
            rspValid_r <= reqValid;                 // RULE20
            if (reqValid) begin
                rsp_r.error <= !singleWireEn || !initDone_r ||
                               mode_r == SGP_DISABLED;  // RULE5 RULE6
                if (mode_r == SGP_INTRUSION) begin
                    rsp_r.level <= latch_r;         // RULE13
                end else begin
                    rsp_r.level <= pinIn;           // RULE14
                end
            end
        end
    end

    assign rspValid = rspValid_r;
    assign rsp = rsp_r;
    assign modeOut = mode_r;
    assign pinOut = level_r;                        // RULE18
    assign pinOe_b = ~(drive_r & singleWireEn);     // RULE18 RULE4
endmodule
`default_nettype wire

// File: sim/sgp_pad_model.sv
`timescale 1ns/100ps
`default_nettype none
module sgp_pad_model (
    input wire logic drvLvl,    // level the device drives
    input wire logic drvOe_b,   // low while the device drives
    input wire logic extLvl,    // switch or led side level
    output logic padLvl         // level seen on the pad
);
    // an active driver wins over the weak switch side
    assign padLvl = drvOe_b ? extLvl : drvLvl;
endmodule
`default_nettype wire

// File: sim/sgp_pin_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module sgp_pin_ctrl_asserts import sgp_pkg::*; (
    input wire logic ref_clk,        // clock
    input wire logic rst_b,          // reset
    input wire logic singleWireEn,   // wire mode
    input wire logic firstWake,      // init
    input wire logic [3:0] modeCfg,  // mode bits
    input wire logic reqValid,       // request
    input wire sgp_req_t req,        // op
    input wire logic rspValid,       // answer
    input wire sgp_rsp_t rsp,        // result
    input wire sgp_mode_t modeOut,   // mode
    input wire logic pinIn,          // pad in
    input wire logic pinOut,         // pad out
    input wire logic pinOe_b         // drive enable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    property p_ans; reqValid |=> rspValid; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_tw; !singleWireEn |-> pinOe_b; endproperty
    a_tw: assert property (p_tw) else $error("driven in two-wire");
    property p_twe; reqValid && !singleWireEn |=> rsp.error; endproperty
    a_twe: assert property (p_twe) else $error("two-wire no error");
    property p_dis; reqValid && modeOut == SGP_DISABLED |=> rsp.error;
    endproperty
    a_dis: assert property (p_dis) else $error("disabled no error");
    property p_in; modeOut inside {SGP_DISABLED, SGP_INPUT, SGP_INTRUSION}
        |-> pinOe_b; endproperty
    a_in: assert property (p_in) else $error("input driven");
    property p_hold; !reqValid && !firstWake
        |=> $stable(pinOut) && $stable(pinOe_b); endproperty
    a_hold: assert property (p_hold) else $error("pin moved");
    property p_wake; firstWake && singleWireEn && modeOut == SGP_DISABLED
        && modeCfg[1:0] == 2'h1 && !modeCfg[3]
        |=> !pinOe_b && pinOut == $past(modeCfg[2]); endproperty
    a_wake: assert property (p_wake) else $error("bad default");
    property p_auth; reqValid && req.op == SGP_OP_HIGH && !req.authOk
        && modeOut == SGP_AUTH_OUT_LOW |=> $stable(pinOut); endproperty
    a_auth: assert property (p_auth) else $error("unauth drive");
    property p_live; reqValid && req.op == SGP_OP_READ
        && modeOut == SGP_INPUT |=> rsp.level == $past(pinIn); endproperty
    a_live: assert property (p_live) else $error("bad live read");
    c_wake: cover property (firstWake && singleWireEn);
    c_intr: cover property (reqValid && modeOut == SGP_INTRUSION);
    c_tw: cover property (reqValid && !singleWireEn);
endmodule
bind sgp_pin_ctrl sgp_pin_ctrl_asserts i_chk (.ref_clk, .rst_b,
    .singleWireEn, .firstWake, .modeCfg, .reqValid, .req, .rspValid, .rsp,
    .modeOut, .pinIn, .pinOut, .pinOe_b);
`default_nettype wire

// File: sim/test_secure_gpio_pin_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_secure_gpio_pin_control;
    import sgp_pkg::*;
    logic ref_clk = 0, rst_b = 0, singleWireEn = 0, firstWake = 0;
    logic authSet = 0, reqValid = 0, extLvl = 1, pinIn, pinOut, pinOe_b;
    logic rspValid, drv, lvl, latch, dis, au, fr, intr, def;
    logic [3:0] modeCfg = 4'h0;
    logic [7:0] rnd = 8'h46;
    logic [4:0] cfgs [8] = '{5'h1C, 5'h11, 5'h15, 5'h19, 5'h1E, 5'h1B,
        5'h17, 5'h03};
    sgp_req_t req = '0;
    sgp_rsp_t rsp;
    sgp_mode_t modeOut, em;
    sgp_rsp_t expQ [$];
    int err_total = 0, comparisons = 0;
    always #25 ref_clk = ~ref_clk;
    sgp_pin_ctrl i_dut (.ref_clk, .rst_b, .singleWireEn, .firstWake,
        .modeCfg, .authSet, .reqValid, .req, .rspValid, .rsp, .modeOut,
        .pinIn, .pinOut, .pinOe_b);
    sgp_pad_model i_pad (.drvLvl(pinOut), .drvOe_b(pinOe_b), .extLvl,
        .padLvl(pinIn));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic note(input logic [2:0] g, input logic [2:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %0t got %0h exp %0h", $time, g, e);
        end
    endtask
    task automatic cmp_rsp(input sgp_rsp_t g, input sgp_rsp_t e);
        note({1'b0, g}, {1'b0, e});
    endtask
    task automatic cmp_pin;
        note({1'b0, pinOe_b, pinOe_b ? 1'b0 : pinOut},
            {1'b0, !drv, drv & lvl});
    endtask
    task automatic cmp_mode(input sgp_mode_t e);
        note(modeOut, e);
    endtask
    task automatic wake(input logic [3:0] cfg, input logic sw);
        rst_b = 0;
        reqValid = 0;
        singleWireEn = sw;
        modeCfg = cfg;
        extLvl = rnd[0];
        rnd = lfsr(rnd);
        dis = !sw || cfg[1:0] == 2'h0;
        au = !dis && cfg[3] == 1'b0 && cfg[1:0] == 2'h1;
        intr = !dis && cfg[3] && cfg[1:0] == 2'h1;
        fr = !dis && cfg[1:0] == 2'h3;
        def = cfg[2];
        drv = au || fr;
        lvl = def;
        latch = 0;
        em = dis ? SGP_DISABLED : au ? (def ? SGP_AUTH_OUT_HIGH :
            SGP_AUTH_OUT_LOW) : intr ? SGP_INTRUSION : fr ? (def ?
            SGP_FREE_OUT_HIGH : SGP_FREE_OUT_LOW) : SGP_INPUT;
        repeat (3) @(negedge ref_clk);
        rst_b = 1;
        firstWake = 1;
        @(negedge ref_clk);
        firstWake = 0;
        cmp_pin();
        cmp_mode(em);
    endtask
    // requests stay back to back until the caller drops reqValid
    task automatic rq(input sgp_op_t op, input logic auth);
        sgp_rsp_t e;
        e.error = dis;
        e.level = intr ? latch : (drv ? lvl : extLvl);
        expQ.push_back(e);
        req = '{op, auth};
        reqValid = 1;
        if ((op == SGP_OP_HIGH || op == SGP_OP_LOW) && (fr || au &&
            ((op == SGP_OP_HIGH) == def || auth)))
            lvl = (op == SGP_OP_HIGH);
        if ((op == SGP_OP_HIGH || op == SGP_OP_LOW) && fr)
            drv = 1;
        if (op == SGP_OP_INPUT && fr)
            drv = 0;
        @(negedge ref_clk);
        cmp_pin();
    endtask
    always @(posedge ref_clk) begin
        #1;
        if (rspValid === 1'b1)
            cmp_rsp(rsp, expQ.pop_front());
    end
    task automatic complete_run;
        if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge ref_clk);
        err_total++;
        complete_run();
    end
    initial begin
        foreach (cfgs[k]) begin
            wake(cfgs[k][3:0], cfgs[k][4]);
            rq(SGP_OP_HIGH, 1'b0);
            rq(SGP_OP_HIGH, 1'b1);
            rq(SGP_OP_LOW, 1'b0);
            rq(SGP_OP_READ, 1'b0);
            reqValid = 0;
            authSet = 1;
            latch = intr;
            @(negedge ref_clk);
            authSet = 0;
            rq(SGP_OP_READ, 1'b0);
            reqValid = 0;
            extLvl = 1;
            @(negedge ref_clk);
            extLvl = 0;
            latch = 0;
            repeat (2) @(negedge ref_clk);
            cmp_pin();
            rq(SGP_OP_READ, 1'b0);
            rq(SGP_OP_INPUT, 1'b0);
            rq(SGP_OP_READ, 1'b0);
        end
        reqValid = 0;
        repeat (2) @(negedge ref_clk);
        complete_run();
    end
endmodule
`default_nettype wire
